//--- tfs_pkg.sv
// tfs_pkg: sizes, action codes and configuration carriers for the trigger flow sequencer.
// assumes the flow configuration is written by a loader outside and held stable per field.
package tfs_pkg;

  // ==========================================================================
  // sizes
  localparam int NUM_STATES = 8;
  localparam int NUM_BRANCH = 4;
  localparam int NUM_EVENTS = 8;
  localparam int NUM_CMP = 8;
  localparam int NUM_CNT = 20;
  localparam int NUM_FLG = 20;
  localparam int CNT_W = 16;
  localparam int POST_W = 16;
  localparam int LUT_IN = 4;
  localparam int LUT_W = 1 << LUT_IN;
  localparam int ST_W = $clog2(NUM_STATES);
  localparam int SEL_W = $clog2(NUM_EVENTS + NUM_CMP);
  localparam int IDX_W = 5;

  // ==========================================================================
  // reset values
  localparam logic [ST_W-1:0] FIRST_STATE = '0;
  localparam logic [CNT_W-1:0] CNT_RST = '0;
  localparam logic [POST_W-1:0] POST_RST = '0;

  // ==========================================================================
  // codes
  typedef enum logic [2:0] {
    CMP_GT, CMP_GE, CMP_EQ, CMP_NE, CMP_LE, CMP_LT
  } tfs_cmp_op_t;

  typedef enum logic [1:0] {
    CA_NONE, CA_INC, CA_DEC, CA_RST
  } tfs_cnt_act_t;

  typedef enum logic [1:0] {
    FA_NONE, FA_SET, FA_CLR
  } tfs_flg_act_t;

  typedef enum logic [1:0] {
    BA_NONE, BA_FINAL, BA_SEG
  } tfs_buf_act_t;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic is_flag;
    logic [IDX_W-1:0] idx;
    tfs_cmp_op_t op;
    logic [CNT_W-1:0] value;
  } tfs_cmp_cfg_t;

  typedef struct packed {
    logic en;
    logic [LUT_W-1:0] lut;
    logic [LUT_IN-1:0][SEL_W-1:0] sel;
    tfs_cnt_act_t [NUM_CNT-1:0] cnt_act;
    tfs_flg_act_t [NUM_FLG-1:0] flg_act;
    tfs_buf_act_t buf_act;
    logic post_given;
    logic [POST_W-1:0] post_cnt;
    logic goto_en;
    logic [ST_W-1:0] goto_state;
  } tfs_branch_cfg_t;

  typedef struct packed {
    tfs_branch_cfg_t [NUM_STATES-1:0][NUM_BRANCH-1:0] br;
    tfs_cmp_cfg_t [NUM_CMP-1:0] cmp;
    logic [NUM_CNT-1:0][CNT_W-1:0] cnt_init;
    logic [NUM_FLG-1:0] flg_init;
  } tfs_flow_cfg_t;

endpackage

//--- tfs_sequencer.sv
// tfs_sequencer: programmable state-based trigger flow with segmented acquisition control.
// assumes probed signals and sample enable come from logic on clock_i; buffer memory is outside.
`timescale 1ns/1ps
`default_nettype none

module tfs_sequencer #(
  parameter int NUM_SEG = 4,
  parameter int SEG_DEPTH = 1024,
  parameter int DATA_W = 32
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic arm_i,
  input wire logic sample_en_i,
  input wire logic [DATA_W-1:0] sample_i,
  input wire logic [tfs_pkg::NUM_EVENTS-1:0] event_i,
  input wire tfs_pkg::tfs_flow_cfg_t cfg_i,
  input wire logic [tfs_pkg::POST_W-1:0] default_post_i,
  output logic running_o,
  output logic done_o,
  output logic [tfs_pkg::ST_W-1:0] state_o,
  output logic wr_en_o,
  output logic [$clog2(NUM_SEG > 1 ? NUM_SEG : 2)-1:0] wr_seg_o,
  output logic [$clog2(SEG_DEPTH)-1:0] wr_addr_o,
  output logic [DATA_W-1:0] wr_data_o,
  output logic discard_o,
  output logic [$clog2(NUM_SEG > 1 ? NUM_SEG : 2)-1:0] discard_seg_o,
  output logic [$clog2(SEG_DEPTH)-1:0] discard_addr_o,
  output logic [tfs_pkg::POST_W-1:0] discard_cnt_o
);

  localparam int SEG_W = $clog2(NUM_SEG > 1 ? NUM_SEG : 2);
  localparam int ADDR_W = $clog2(SEG_DEPTH);
  localparam int POOL_W = tfs_pkg::NUM_EVENTS + tfs_pkg::NUM_CMP;

  typedef enum logic [2:0] {
    BS_IDLE, BS_ACQ, BS_POST, BS_FINAL, BS_DONE
  } tfs_buf_state_t;

  // ==========================================================================
  // helpers
  function automatic logic cmp_eval(input tfs_pkg::tfs_cmp_op_t op,
                                    input logic [tfs_pkg::CNT_W-1:0] a,
                                    input logic [tfs_pkg::CNT_W-1:0] b);
    logic r;
    r = 1'b0;
    unique case (op)
      tfs_pkg::CMP_GT: r = a > b;
      tfs_pkg::CMP_GE: r = a >= b;
      tfs_pkg::CMP_EQ: r = a == b;
      tfs_pkg::CMP_NE: r = a != b;
      tfs_pkg::CMP_LE: r = a <= b;
      tfs_pkg::CMP_LT: r = a < b;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [ADDR_W-1:0] off_next(input logic [ADDR_W-1:0] o);
    return (o == ADDR_W'(SEG_DEPTH - 1)) ? '0 : o + 1'b1;
  endfunction

  function automatic logic [SEG_W-1:0] seg_next(input logic [SEG_W-1:0] s);
    // wraps onto the oldest segment once every one has been used
    return (s == SEG_W'(NUM_SEG - 1)) ? '0 : s + 1'b1;
  endfunction

  // ==========================================================================
  // state
  logic [tfs_pkg::ST_W-1:0] state_r;
  logic running_r;
  logic [tfs_pkg::NUM_CNT-1:0][tfs_pkg::CNT_W-1:0] cnt_r;
  logic [tfs_pkg::NUM_FLG-1:0] flg_r;
  tfs_buf_state_t bst_r;
  logic [SEG_W-1:0] seg_r;
  logic [ADDR_W-1:0] off_r;
  logic [tfs_pkg::POST_W-1:0] post_r;
  logic wr_en_r;
  logic [SEG_W-1:0] wr_seg_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [DATA_W-1:0] wr_data_r;
  logic discard_r;
  logic [SEG_W-1:0] discard_seg_r;
  logic [ADDR_W-1:0] discard_addr_r;
  logic [tfs_pkg::POST_W-1:0] discard_cnt_r;

  // ==========================================================================
  // comparators
  logic [tfs_pkg::NUM_CMP-1:0] cmp_hit;
  logic [tfs_pkg::CNT_W-1:0] cmp_opnd;

  // an index past the last counter or flag reads as zero, never aliases another one
  always_comb begin
    cmp_opnd = '0;
    for (int c = 0; c < tfs_pkg::NUM_CMP; c++) begin
      cmp_opnd = '0;
      if (cfg_i.cmp[c].is_flag) begin
        if (int'(cfg_i.cmp[c].idx) < tfs_pkg::NUM_FLG) begin
          cmp_opnd = tfs_pkg::CNT_W'(flg_r[cfg_i.cmp[c].idx]);
        end
      end else if (int'(cfg_i.cmp[c].idx) < tfs_pkg::NUM_CNT) begin
        cmp_opnd = cnt_r[cfg_i.cmp[c].idx];
      end
      cmp_hit[c] = cmp_eval(cfg_i.cmp[c].op, cmp_opnd, cfg_i.cmp[c].value);
    end
  end

  // ==========================================================================
  // branch evaluation
  logic [POOL_W-1:0] pool;
  logic [tfs_pkg::LUT_IN-1:0] lut_idx;
  tfs_pkg::tfs_branch_cfg_t br;
  tfs_pkg::tfs_branch_cfg_t win_br;
  logic win_hit;
  logic fire;
  tfs_pkg::tfs_buf_act_t buf_act;
  logic [tfs_pkg::POST_W-1:0] post_load;

  assign pool = {cmp_hit, event_i};

  always_comb begin
    win_hit = 1'b0;
    win_br = '0;
    br = '0;
    lut_idx = '0;
    // only the active state's branch set is looked at
    for (int b = 0; b < tfs_pkg::NUM_BRANCH; b++) begin
      br = cfg_i.br[state_r][b];
      for (int k = 0; k < tfs_pkg::LUT_IN; k++) begin
        lut_idx[k] = (int'(br.sel[k]) < POOL_W) ? pool[br.sel[k]] : 1'b0;
      end
      // a truth table covers every mix of not, and, or and grouping
      // an else branch is a table of all ones in the last enabled slot
      if (br.en && br.lut[lut_idx] && !win_hit) begin
        win_hit = 1'b1;
        win_br = br;
      end
    end
  end

  // buffer actions need the run flag, so nothing fires after the final trigger
  assign fire = running_r && sample_en_i && win_hit;
  assign buf_act = fire ? win_br.buf_act : tfs_pkg::BA_NONE;
  assign post_load = win_br.post_given ? win_br.post_cnt : default_post_i;

  // ==========================================================================
  // flow state and run flag
  // arm outranks a firing branch so a restart always begins clean
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_r <= tfs_pkg::FIRST_STATE;
    end else if (arm_i) begin
      state_r <= tfs_pkg::FIRST_STATE;
    end else if (fire && win_br.goto_en) begin
      state_r <= win_br.goto_state;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      running_r <= 1'b0;
    end else if (arm_i) begin
      running_r <= 1'b1;
    end else if (buf_act == tfs_pkg::BA_FINAL) begin
      running_r <= 1'b0;
    end
  end

  // ==========================================================================
  // counters and flags
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cnt_r <= {tfs_pkg::NUM_CNT{tfs_pkg::CNT_RST}};
    end else if (arm_i) begin
      cnt_r <= cfg_i.cnt_init;
    end else if (fire) begin
      for (int i = 0; i < tfs_pkg::NUM_CNT; i++) begin
        unique case (win_br.cnt_act[i])
          tfs_pkg::CA_INC: cnt_r[i] <= cnt_r[i] + 1'b1;
          tfs_pkg::CA_DEC: cnt_r[i] <= cnt_r[i] - 1'b1;
          tfs_pkg::CA_RST: cnt_r[i] <= cfg_i.cnt_init[i];
          default: cnt_r[i] <= cnt_r[i];
        endcase
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      flg_r <= '0;
    end else if (arm_i) begin
      flg_r <= cfg_i.flg_init;
    end else if (fire) begin
      for (int i = 0; i < tfs_pkg::NUM_FLG; i++) begin
        if (win_br.flg_act[i] == tfs_pkg::FA_SET) begin
          flg_r[i] <= 1'b1;
        end else if (win_br.flg_act[i] == tfs_pkg::FA_CLR) begin
          flg_r[i] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // acquisition control
  // a post-fill count of n writes n samples after the triggering one;
  // the sample that finds the count at zero is dropped after the final trigger, else it opens the next segment
  // limitation: a post-fill longer than a segment wraps over its older samples
  // a cut segment hands its trigger sample to the next one, so no sample is lost
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      bst_r <= BS_IDLE;
      seg_r <= '0;
      off_r <= '0;
      post_r <= tfs_pkg::POST_RST;
      wr_en_r <= 1'b0;
      wr_seg_r <= '0;
      wr_addr_r <= '0;
      wr_data_r <= '0;
      discard_r <= 1'b0;
      discard_seg_r <= '0;
      discard_addr_r <= '0;
      discard_cnt_r <= tfs_pkg::POST_RST;
    end else begin
      wr_en_r <= 1'b0;
      discard_r <= 1'b0;
      if (arm_i) begin
        bst_r <= BS_ACQ;
        seg_r <= '0;
        off_r <= '0;
        post_r <= tfs_pkg::POST_RST;
      end else if (sample_en_i) begin
        unique case (bst_r)
          BS_IDLE, BS_DONE: begin
          end
          BS_ACQ: begin
            wr_en_r <= 1'b1;
            wr_seg_r <= seg_r;
            wr_addr_r <= off_r;
            wr_data_r <= sample_i;
            off_r <= off_next(off_r);
            if (buf_act == tfs_pkg::BA_SEG) begin
              bst_r <= BS_POST;
              post_r <= post_load;
            end else if (buf_act == tfs_pkg::BA_FINAL) begin
              bst_r <= BS_FINAL;
              post_r <= post_load;
            end
          end
          BS_POST: begin
            // the new trigger sample opens the next segment either way
            if (buf_act != tfs_pkg::BA_NONE || post_r == tfs_pkg::POST_RST) begin
              if (post_r != tfs_pkg::POST_RST) begin
                discard_r <= 1'b1;
                discard_seg_r <= seg_r;
                discard_addr_r <= off_r;
                discard_cnt_r <= post_r;
              end
              seg_r <= seg_next(seg_r);
              off_r <= ADDR_W'(1);
              wr_en_r <= 1'b1;
              wr_seg_r <= seg_next(seg_r);
              wr_addr_r <= '0;
              wr_data_r <= sample_i;
              post_r <= post_load;
              if (buf_act == tfs_pkg::BA_SEG) begin
                bst_r <= BS_POST;
              end else if (buf_act == tfs_pkg::BA_FINAL) begin
                bst_r <= BS_FINAL;
              end else begin
                bst_r <= BS_ACQ;
              end
            end else begin
              wr_en_r <= 1'b1;
              wr_seg_r <= seg_r;
              wr_addr_r <= off_r;
              wr_data_r <= sample_i;
              off_r <= off_next(off_r);
              post_r <= post_r - 1'b1;
            end
          end
          BS_FINAL: begin
            if (post_r == tfs_pkg::POST_RST) begin
              bst_r <= BS_DONE;
            end else begin
              wr_en_r <= 1'b1;
              wr_seg_r <= seg_r;
              wr_addr_r <= off_r;
              wr_data_r <= sample_i;
              off_r <= off_next(off_r);
              post_r <= post_r - 1'b1;
            end
          end
          default: bst_r <= BS_IDLE;
        endcase
      end
    end
  end

  // ==========================================================================
  // outputs
  // done is decoded from the buffer state and holds until the next arm
  assign running_o = running_r;
  assign done_o = (bst_r == BS_DONE);
  assign state_o = state_r;
  assign wr_en_o = wr_en_r;
  assign wr_seg_o = wr_seg_r;
  assign wr_addr_o = wr_addr_r;
  assign wr_data_o = wr_data_r;
  assign discard_o = discard_r;
  assign discard_seg_o = discard_seg_r;
  assign discard_addr_o = discard_addr_r;
  assign discard_cnt_o = discard_cnt_r;

endmodule // tfs_sequencer

`default_nettype wire

//--- tfs_sequencer_assertions.sv
// checker: port timing relations of the trigger flow sequencer
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module tfs_sequencer_checker #(
  parameter int NUM_SEG = 4,
  parameter int SEG_DEPTH = 1024,
  parameter int DATA_W = 32
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic arm_i,
  input wire logic sample_en_i,
  input wire logic [DATA_W-1:0] sample_i,
  input wire logic [tfs_pkg::NUM_EVENTS-1:0] event_i,
  input wire tfs_pkg::tfs_flow_cfg_t cfg_i,
  input wire logic [tfs_pkg::POST_W-1:0] default_post_i,
  input wire logic running_o,
  input wire logic done_o,
  input wire logic [tfs_pkg::ST_W-1:0] state_o,
  input wire logic wr_en_o,
  input wire logic [$clog2(NUM_SEG > 1 ? NUM_SEG : 2)-1:0] wr_seg_o,
  input wire logic [$clog2(SEG_DEPTH)-1:0] wr_addr_o,
  input wire logic [DATA_W-1:0] wr_data_o,
  input wire logic discard_o,
  input wire logic [$clog2(NUM_SEG > 1 ? NUM_SEG : 2)-1:0] discard_seg_o,
  input wire logic [$clog2(SEG_DEPTH)-1:0] discard_addr_o,
  input wire logic [tfs_pkg::POST_W-1:0] discard_cnt_o
);
  // ==========================================================================
  // assertions
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);

  a_arm_first_state: assert property (arm_i |=> running_o && state_o == '0 && !done_o)
    else $error("arm did not start in first state");
  a_idle_state_hold: assert property (!running_o && !arm_i |=> $stable(state_o))
    else $error("state moved while idle");
  a_nohit_state_hold: assert property (running_o && !sample_en_i && !arm_i |=> $stable(state_o))
    else $error("state moved without sample");
  a_write_data_src: assert property (wr_en_o |-> $past(sample_en_i) && wr_data_o == $past(sample_i))
    else $error("write data not last sample");
  a_done_no_write: assert property (done_o |-> !wr_en_o && !running_o)
    else $error("write or run after done");
  a_done_holds: assert property (done_o && !arm_i |=> done_o)
    else $error("done dropped without arm");
  // a cut segment hands its trigger sample to offset 0 of the following segment
  a_cut_moves_on: assert property (discard_o |-> wr_en_o && wr_addr_o == '0 &&
    wr_seg_o == discard_seg_o + 1'b1 && discard_cnt_o != '0)
    else $error("cut segment not followed correctly");
  a_addr_step: assert property ((wr_en_o && !arm_i) ##1 (wr_en_o && !arm_i && $stable(wr_seg_o))
    |-> wr_addr_o == $past(wr_addr_o) + 1'b1)
    else $error("write offset did not step");
  a_seg_step: assert property ((wr_en_o && !arm_i) ##1 (wr_en_o && !arm_i && $changed(wr_seg_o))
    |-> wr_addr_o == '0 && wr_seg_o == $past(wr_seg_o) + 1'b1)
    else $error("segment did not advance by one");

  c_discard: cover property (discard_o);
  c_done: cover property ($rose(done_o));
  c_seg_wrap: cover property (wr_en_o && $past(wr_seg_o) != '0 && wr_seg_o == '0);
endmodule // tfs_sequencer_checker

bind tfs_sequencer tfs_sequencer_checker #(.NUM_SEG(NUM_SEG), .SEG_DEPTH(SEG_DEPTH),
  .DATA_W(DATA_W)) u_tfs_sequencer_checker (
  .clock_i(clock_i), .srst_i(srst_i), .arm_i(arm_i), .sample_en_i(sample_en_i),
  .sample_i(sample_i), .event_i(event_i), .cfg_i(cfg_i), .default_post_i(default_post_i),
  .running_o(running_o), .done_o(done_o), .state_o(state_o), .wr_en_o(wr_en_o),
  .wr_seg_o(wr_seg_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .discard_o(discard_o),
  .discard_seg_o(discard_seg_o), .discard_addr_o(discard_addr_o), .discard_cnt_o(discard_cnt_o));
`default_nettype wire

//--- tfs_probe_model.sv
// tfs_probe_model: stands in for the probed user design feeding samples and events
// assumes rnd_i carries a fresh random word every cycle
`timescale 1ns/1ps
`default_nettype none
module tfs_probe_model #(
  parameter int DATA_W = 32
) (
  input wire logic clock_i,
  input wire logic [31:0] rnd_i,
  input wire logic quiet_i,
  input wire logic slow_i,
  output logic sample_en_o,
  output logic [tfs_pkg::NUM_EVENTS-1:0] event_o,
  output logic [DATA_W-1:0] sample_o
);
  logic en_r;
  // launched on the falling edge; data keeps changing even without a sample
  always_ff @(negedge clock_i) begin
    en_r <= slow_i ? (rnd_i[1:0] == 2'h0) : (rnd_i[1:0] != 2'h0);
    event_o <= rnd_i[9:2];
    sample_o <= DATA_W'({rnd_i[31:10], rnd_i[9:0] ^ 10'h3a5});
  end
  assign sample_en_o = en_r & ~quiet_i;
endmodule // tfs_probe_model
`default_nettype wire

//--- tb_top.sv
// tb_top: random and directed flows checked against a reference model
// assumes the probe model supplies samples; the bench drives arm, config and reset
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock_i, srst_i, arm_i, quiet, slow, sample_en_i, running_o, done_o, wr_en_o, dis_o;
  logic [31:0] sample_i, rnd, rs, wr_data_o, e_data;
  logic [7:0] event_i;
  tfs_pkg::tfs_flow_cfg_t cfg_i;
  logic [15:0] default_post_i, dcnt_o, m_left, e_dcnt;
  logic [15:0] m_cnt [20];
  logic [19:0] m_flg;
  logic [2:0] state_o, m_st;
  logic [1:0] wr_seg_o, dseg_o, m_seg, e_seg, e_dseg;
  logic [3:0] wr_addr_o, daddr_o, m_addr, e_addr, e_daddr;
  logic m_run, m_act, m_done, m_post, m_fin, e_wr, e_dis;
  int num_errors, n_compared;

  tfs_sequencer #(.NUM_SEG(4), .SEG_DEPTH(16), .DATA_W(32)) u_tfs_sequencer (
    .clock_i(clock_i), .srst_i(srst_i), .arm_i(arm_i), .sample_en_i(sample_en_i),
    .sample_i(sample_i), .event_i(event_i), .cfg_i(cfg_i), .default_post_i(default_post_i),
    .running_o(running_o), .done_o(done_o), .state_o(state_o), .wr_en_o(wr_en_o),
    .wr_seg_o(wr_seg_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .discard_o(dis_o),
    .discard_seg_o(dseg_o), .discard_addr_o(daddr_o), .discard_cnt_o(dcnt_o));
  tfs_probe_model #(.DATA_W(32)) u_tfs_probe_model (.clock_i(clock_i), .rnd_i(rnd),
    .quiet_i(quiet), .slow_i(slow), .sample_en_o(sample_en_i), .event_o(event_i),
    .sample_o(sample_i));

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  always @(posedge clock_i) rnd <= srst_i ? lfsr(32'h6a9a) : lfsr(rnd);

  // ==========================================================================
  // random source and reference model
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return v[0] ? ((v >> 1) ^ 32'h80200003) : (v >> 1);
  endfunction
  function automatic logic [31:0] nxt();
    rs = lfsr(rs);
    return rs;
  endfunction
  function automatic bit cmp_hit(input tfs_pkg::tfs_cmp_cfg_t c);
    logic [15:0] a;
    a = c.is_flag ? 16'(m_flg[c.idx]) : m_cnt[c.idx];
    case (c.op)
      tfs_pkg::CMP_GT: return a > c.value;
      tfs_pkg::CMP_GE: return a >= c.value;
      tfs_pkg::CMP_EQ: return a == c.value;
      tfs_pkg::CMP_NE: return a != c.value;
      tfs_pkg::CMP_LE: return a <= c.value;
      default: return a < c.value;
    endcase
  endfunction
  task automatic wr();
    {e_wr, e_seg, e_addr, e_data} = {1'b1, m_seg, m_addr, sample_i};
    m_addr++;
  endtask
  task automatic model_step();
    logic [15:0] pool;
    logic [3:0] idx;
    int hit;
    tfs_pkg::tfs_branch_cfg_t br;
    {e_wr, e_dis, hit} = {2'h0, -32'sd1};
    if (srst_i) {m_st, m_run, m_act, m_done, m_post} = '0;
    if (srst_i) return;
    if (arm_i) begin
      {m_st, m_done, m_post, m_seg, m_addr, m_run, m_act} = 13'h3;
      for (int c = 0; c < 20; c++) m_cnt[c] = cfg_i.cnt_init[c];
      m_flg = cfg_i.flg_init;
      return;
    end
    if (!(sample_en_i && m_act)) return;
    for (int c = 0; c < 8; c++) pool[c] = event_i[c];
    for (int c = 0; c < 8; c++) pool[c + 8] = cmp_hit(cfg_i.cmp[c]);
    for (int b = 3; b >= 0; b--) begin
      br = cfg_i.br[m_st][b];
      for (int k = 0; k < 4; k++) idx[k] = pool[br.sel[k]];
      if (m_run && br.en && br.lut[idx]) hit = b;
    end
    if (hit >= 0) br = cfg_i.br[m_st][hit];
    for (int c = 0; c < 20 && hit >= 0; c++) begin
      case (br.cnt_act[c])
        tfs_pkg::CA_INC: m_cnt[c] = m_cnt[c] + 16'h1;
        tfs_pkg::CA_DEC: m_cnt[c] = m_cnt[c] - 16'h1;
        tfs_pkg::CA_RST: m_cnt[c] = cfg_i.cnt_init[c];
        default: ;
      endcase
      if (br.flg_act[c] == tfs_pkg::FA_SET) m_flg[c] = 1'b1;
      if (br.flg_act[c] == tfs_pkg::FA_CLR) m_flg[c] = 1'b0;
    end
    if (hit >= 0 && br.goto_en) m_st = br.goto_state;
    if (hit >= 0 && br.buf_act != tfs_pkg::BA_NONE) begin
      if (m_post) begin
        {e_dis, e_dseg, e_daddr, e_dcnt} = {m_left != 0, m_seg, m_addr, m_left};
        {m_seg, m_addr} = {m_seg + 2'h1, 4'h0};
      end
      wr();
      m_left = br.post_given ? br.post_cnt : default_post_i;
      {m_post, m_fin} = {1'b1, br.buf_act == tfs_pkg::BA_FINAL};
      if (m_fin) m_run = 1'b0;
    end else if (m_post && m_left == 0) begin
      if (m_fin) {m_act, m_done} = 2'h1;
      else begin
        {m_seg, m_addr, m_post} = {m_seg + 2'h1, 5'h0};
        wr();
      end
    end else begin
      if (m_post) m_left--;
      wr();
    end
  endtask

  // ==========================================================================
  // stimulus and comparison
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic gen_cfg(input bit dir);
    logic [31:0] r;
    for (int s = 0; s < 8; s++) begin
      for (int b = 0; b < 4; b++) begin
        r = nxt();
        cfg_i.br[s][b].en = dir ? (s == 0 && b < 3) : r[0];
        // directed flow: branch b fires on event b; branches 0 and 1 close a segment, branch 2 is the final trigger
        cfg_i.br[s][b].lut = dir ? 16'haaaa : r[31:16];
        for (int k = 0; k < 4; k++) cfg_i.br[s][b].sel[k] = dir ? 4'(b) : 4'(nxt());
        for (int c = 0; c < 20; c++) cfg_i.br[s][b].cnt_act[c] = tfs_pkg::tfs_cnt_act_t'(2'(nxt()));
        for (int c = 0; c < 20; c++) cfg_i.br[s][b].flg_act[c] = tfs_pkg::tfs_flg_act_t'(2'(nxt() % 3));
        cfg_i.br[s][b].buf_act = tfs_pkg::tfs_buf_act_t'(dir ? (b == 2 ? 2'h1 : 2'h2) :
          (r[2:0] == 3'h0 ? 2'h1 : r[2:0] < 3'h3 ? 2'h2 : 2'h0));
        cfg_i.br[s][b].post_given = dir ? (b != 2) : r[3];
        cfg_i.br[s][b].post_cnt = dir ? (b == 0 ? 16'h2 : 16'h5) : 16'(r[8:4]);
        {cfg_i.br[s][b].goto_en, cfg_i.br[s][b].goto_state} = {r[9], dir ? 3'h0 : r[12:10]};
      end
    end
    for (int c = 0; c < 8; c++) begin
      r = nxt();
      cfg_i.cmp[c] = {r[0], 5'(r[15:8] % 20), 3'(r[7:4] % 6), 16'(r[19:16])};
    end
    for (int c = 0; c < 20; c++) {cfg_i.cnt_init[c], cfg_i.flg_init[c]} = 17'(nxt() & 15);
    r = nxt();
    if (!dir) cfg_i.br[r[2:0]][r[4:3]].buf_act = tfs_pkg::BA_FINAL;
    {default_post_i, slow} = {16'(r[9:5]), r[10]};
  endtask
  task automatic cycle(input logic a, input logic rst, input logic mut);
    @(negedge clock_i);
    check_val("state", 32'(m_st), 32'(state_o));
    check_val("running", 32'(m_run), 32'(running_o));
    check_val("done", 32'(m_done), 32'(done_o));
    check_val("wr_en", 32'(e_wr), 32'(wr_en_o));
    if (e_wr) check_val("wr_pos", 32'({e_seg, e_addr}), 32'({wr_seg_o, wr_addr_o}));
    if (e_wr) check_val("wr_data", e_data, wr_data_o);
    check_val("discard", 32'(e_dis), 32'(dis_o));
    if (e_dis) check_val("discard_info", {e_dseg, e_daddr, 10'h0, e_dcnt},
      {dseg_o, daddr_o, 10'h0, dcnt_o});
    {arm_i, quiet, srst_i} = {a, a, rst};
    if (mut) cfg_i.cmp[nxt() % 8].value = 16'(nxt() & 7);
    #1;
    model_step();
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    {srst_i, arm_i, quiet, slow, cfg_i, default_post_i} = '0;
    {m_st, m_run, m_act, m_done, m_post, m_fin, e_wr, e_dis} = '0;
    {num_errors, n_compared, rs} = {64'h0, 32'h6a9a};
    srst_i = 1'b1;
    repeat (8) @(posedge clock_i);
    repeat (3) cycle(1'b0, 1'b0, 1'b0);
    for (int t = 0; t < 14; t++) begin
      gen_cfg(t >= 10);
      cycle(1'b1, 1'b0, 1'b0);
      for (int i = 0; i < 150 && !m_done; i++) cycle(1'b0, t == 13 && i == 2, i == 70);
      cycle(1'b0, 1'b0, 1'b0);
      // quiet re-arm so the next flow's config never meets a sample judged by the old one
      cycle(1'b1, 1'b0, 1'b0);
      $display("flow %0d ended, mismatches so far %0d", t, num_errors);
    end
    report_and_stop();
  end
  initial begin
    #32000;
    num_errors++;
    $display("BAD watchdog expected finish seen hang");
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
